// ===== ust_core.sv
// full-duplex serial transceiver: framing, queues, flow control, infrared and line driver
`timescale 1ns/1ns
module ust_core
    import ust_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire ust_cfg_t cfg,
    input wire logic flags_clr,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [UST_DATA_W-1:0] tx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [UST_DATA_W-1:0] rx_data,
    output ust_flags_t flags,
    output ust_irq_t irq,
    output logic tx_dma_req,
    output logic rx_dma_req,
    output logic txd,
    input wire logic rxd,
    output logic sck,
    output logic rts_n,
    input wire logic cts_n,
    output logic drv_en
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        ust_tx_st_t tx_st;
        logic [4:0] tx_tick;
        logic [3:0] tx_bit;
        logic [8:0] tx_shift;
        logic tx_par;
        logic tx_stop2;
        logic tx_line;
        logic txd;
        logic sck;
        logic drv_en;
        ust_rx_st_t rx_st;
        logic [4:0] rx_tick;
        logic [3:0] rx_bit;
        logic [8:0] rx_shift;
        logic rx_par;
        logic rx_push;
        logic [8:0] rx_word;
        logic [4:0] ir_cnt;
        logic [4:0] bp_tick;
        logic [7:0] low_bits;
        logic [7:0] idle_bits;
        logic rts_n;
        logic parity_err;
        logic overrun_err;
        logic frame_err;
        logic break_det;
        logic rx_timeout;
    } ust_core_st_t;

    ust_core_st_t st_ff;
    ust_core_st_t nxt_st;

    logic tick;
    logic txf_valid;
    logic txf_pop;
    logic [UST_DATA_W-1:0] txf_data;
    logic [UST_LVL_W-1:0] txf_level;
    logic txf_in_ready;
    logic rxf_in_ready;
    logic [UST_LVL_W-1:0] rxf_level;

    logic [4:0] tpb;
    logic [4:0] half;
    logic [3:0] nbits;
    logic [3:0] frame_bits;
    logic line_in;
    logic bit_end_tx;
    logic bit_end_rx;
    logic bp_pulse;

    // puts the first-sent bit at position 0 for msb-first characters
    function automatic logic [8:0] ust_rev(input logic [8:0] d, input logic [3:0] n);
        logic [8:0] r;
        r = '0;
        for (int i = 0; i < 9; i++)
        begin
            if (i < int'(n))
                r[i] = d[int'(n) - 1 - i];
        end
        return r;
    endfunction

    // ****************************************
    // timing and queues
    // ****************************************
    ust_tick_div u_div
    (
        .core_clk(core_clk),
        .rst(rst),
        .div(cfg.baud_div),
        .tick(tick)
    );

    // shorter bit in synchronous mode: the clock out needs no oversampling
    assign tpb = cfg.sync_mode ? UST_TICKS_SYNC : UST_TICKS_ASYNC;
    assign half = tpb >> 1;
    assign nbits = (cfg.wlen == UST_WL_7) ? 4'h7 : (cfg.wlen == UST_WL_9) ? 4'h9 : 4'h8;
    assign frame_bits = 4'h1 + nbits + {3'h0, cfg.parity_en} + {3'h0, cfg.two_stop} + 4'h1;

    ust_fifo #(.W(UST_DATA_W), .D(UST_FIFO_DEPTH)) u_txf
    (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(tx_valid),
        .in_ready(txf_in_ready),
        .in_data(tx_data),
        .out_valid(txf_valid),
        .out_ready(txf_pop),
        .out_data(txf_data),
        .level(txf_level)
    );

    ust_fifo #(.W(UST_DATA_W), .D(UST_FIFO_DEPTH)) u_rxf
    (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(st_ff.rx_push),
        .in_ready(rxf_in_ready),
        .in_data(st_ff.rx_word),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data),
        .level(rxf_level)
    );

    assign tx_ready = txf_in_ready;
    // pop only when the idle transmitter may start: flow control holds it off
    assign txf_pop = (st_ff.tx_st == TX_IDLE) && txf_valid && !(cfg.flow_en && cts_n);
    // infrared input: a high pulse stands for a zero bit, stretched over one bit
    assign line_in = cfg.irda_en ? (st_ff.ir_cnt == '0) : rxd;
    assign bit_end_tx = tick && (st_ff.tx_tick == tpb - 5'h01);
    assign bit_end_rx = tick && (st_ff.rx_tick == tpb - 5'h01);
    assign bp_pulse = tick && (st_ff.bp_tick == tpb - 5'h01);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rx_push = 1'b0;

        // transmitter, independent of the receiver below
        if (txf_pop)
        begin
            nxt_st.tx_st = TX_START;
            nxt_st.tx_shift = cfg.msb_first ? ust_rev(txf_data, nbits) : txf_data;
            nxt_st.tx_tick = UST_RST_TICK;
            nxt_st.tx_par = cfg.parity_odd;
            nxt_st.tx_line = 1'b0;
        end
        else if (st_ff.tx_st != TX_IDLE && tick)
        begin
            nxt_st.tx_tick = bit_end_tx ? UST_RST_TICK : st_ff.tx_tick + 5'h01;
            if (bit_end_tx)
            begin
                case (st_ff.tx_st)
                    TX_START:
                    begin
                        nxt_st.tx_st = TX_DATA;
                        nxt_st.tx_bit = 4'h0;
                        nxt_st.tx_line = st_ff.tx_shift[0];
                        nxt_st.tx_par = st_ff.tx_par ^ st_ff.tx_shift[0];
                        nxt_st.tx_shift = st_ff.tx_shift >> 1;
                    end
                    TX_DATA:
                    begin
                        nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                        if (st_ff.tx_bit == nbits - 4'h1)
                        begin
                            nxt_st.tx_st = cfg.parity_en ? TX_PAR : TX_STOP;
                            nxt_st.tx_line = cfg.parity_en ? st_ff.tx_par : 1'b1;
                            nxt_st.tx_stop2 = cfg.two_stop;
                        end
                        else
                        begin
                            nxt_st.tx_line = st_ff.tx_shift[0];
                            nxt_st.tx_par = st_ff.tx_par ^ st_ff.tx_shift[0];
                            nxt_st.tx_shift = st_ff.tx_shift >> 1;
                        end
                    end
                    TX_PAR:
                    begin
                        nxt_st.tx_st = TX_STOP;
                        nxt_st.tx_line = 1'b1;
                    end
                    TX_STOP:
                    begin
                        if (st_ff.tx_stop2)
                            nxt_st.tx_stop2 = 1'b0;
                        else
                            nxt_st.tx_st = TX_IDLE;
                    end
                    default:
                        nxt_st.tx_st = TX_IDLE;
                endcase
            end
        end

        // pin drivers follow the next transmit state so they line up with it
        if (cfg.irda_en && nxt_st.tx_st != TX_IDLE)
            nxt_st.txd = !nxt_st.tx_line && (nxt_st.tx_tick < UST_IR_PULSE_TICKS);
        else if (cfg.irda_en)
            nxt_st.txd = 1'b0;
        else
            nxt_st.txd = (nxt_st.tx_st == TX_IDLE) ? 1'b1 : nxt_st.tx_line;
        // bit clock only over data bits, rising mid-bit where the data is stable
        nxt_st.sck = cfg.sync_mode && (nxt_st.tx_st == TX_DATA) && (nxt_st.tx_tick >= half);
        nxt_st.drv_en = cfg.rs485_en && (nxt_st.tx_st != TX_IDLE);

        // infrared pulse stretcher
        if (rxd)
            nxt_st.ir_cnt = tpb;
        else if (tick && st_ff.ir_cnt != '0)
            nxt_st.ir_cnt = st_ff.ir_cnt - 5'h01;

        // receiver
        case (st_ff.rx_st)
            RX_IDLE:
            begin
                if (!line_in)
                begin
                    nxt_st.rx_st = RX_START;
                    nxt_st.rx_tick = UST_RST_TICK;
                end
            end
            RX_START:
            begin
                if (tick)
                begin
                    nxt_st.rx_tick = st_ff.rx_tick + 5'h01;
                    // recheck at mid-bit so a glitch does not start a character
                    if (st_ff.rx_tick == half - 5'h01)
                    begin
                        nxt_st.rx_st = line_in ? RX_IDLE : RX_DATA;
                        nxt_st.rx_tick = UST_RST_TICK;
                        nxt_st.rx_bit = 4'h0;
                        nxt_st.rx_par = 1'b0;
                        nxt_st.rx_shift = UST_RST_SHIFT;
                    end
                end
            end
            RX_DATA:
            begin
                if (tick)
                    nxt_st.rx_tick = bit_end_rx ? UST_RST_TICK : st_ff.rx_tick + 5'h01;
                if (bit_end_rx)
                begin
                    nxt_st.rx_shift = {line_in, st_ff.rx_shift[8:1]};
                    nxt_st.rx_par = st_ff.rx_par ^ line_in;
                    nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
                    if (st_ff.rx_bit == nbits - 4'h1)
                        nxt_st.rx_st = cfg.parity_en ? RX_PAR : RX_STOP;
                end
            end
            RX_PAR:
            begin
                if (tick)
                    nxt_st.rx_tick = bit_end_rx ? UST_RST_TICK : st_ff.rx_tick + 5'h01;
                if (bit_end_rx)
                begin
                    nxt_st.rx_st = RX_STOP;
                    if ((st_ff.rx_par ^ line_in) != cfg.parity_odd)
                        nxt_st.parity_err = 1'b1;
                end
            end
            RX_STOP:
            begin
                if (tick)
                    nxt_st.rx_tick = bit_end_rx ? UST_RST_TICK : st_ff.rx_tick + 5'h01;
                if (bit_end_rx)
                begin
                    nxt_st.rx_st = RX_IDLE;
                    nxt_st.idle_bits = UST_RST_CNT;
                    if (!line_in)
                        nxt_st.frame_err = 1'b1;
                    // one writer only, so the queue cannot fill before the push lands
                    if (rxf_in_ready)
                    begin
                        nxt_st.rx_push = 1'b1;
                        nxt_st.rx_word = st_ff.rx_shift >> (4'h9 - nbits);
                        if (cfg.msb_first)
                            nxt_st.rx_word = ust_rev(st_ff.rx_shift >> (4'h9 - nbits), nbits);
                    end
                    else
                    begin
                        nxt_st.overrun_err = 1'b1;
                    end
                end
            end
            default:
                nxt_st.rx_st = RX_IDLE;
        endcase

        // bit-period timebase for break and timeout
        if (tick)
            nxt_st.bp_tick = bp_pulse ? UST_RST_TICK : st_ff.bp_tick + 5'h01;
        if (line_in)
            nxt_st.low_bits = UST_RST_CNT;
        else if (bp_pulse && st_ff.low_bits != 8'hFF)
            nxt_st.low_bits = st_ff.low_bits + 8'h01;
        if (bp_pulse && st_ff.low_bits > {4'h0, frame_bits})
            nxt_st.break_det = 1'b1;
        if (!rx_valid)
            nxt_st.idle_bits = UST_RST_CNT;
        else if (bp_pulse && st_ff.rx_st == RX_IDLE && st_ff.idle_bits != 8'hFF)
            nxt_st.idle_bits = st_ff.idle_bits + 8'h01;
        if (flags_clr)
        begin
            nxt_st.parity_err = 1'b0;
            nxt_st.overrun_err = 1'b0;
            nxt_st.frame_err = 1'b0;
            nxt_st.break_det = 1'b0;
            nxt_st.rx_timeout = 1'b0;
        end
        // set after clear: an error in the clearing cycle is kept
        if (st_ff.rx_st == RX_PAR && bit_end_rx && (st_ff.rx_par ^ line_in) != cfg.parity_odd)
            nxt_st.parity_err = 1'b1;
        if (st_ff.rx_st == RX_STOP && bit_end_rx)
        begin
            if (!line_in)
                nxt_st.frame_err = 1'b1;
            if (!rxf_in_ready)
                nxt_st.overrun_err = 1'b1;
        end
        if (bp_pulse && st_ff.low_bits > {4'h0, frame_bits})
            nxt_st.break_det = 1'b1;
        if (rx_valid && cfg.timeout_bits != '0 && st_ff.idle_bits >= cfg.timeout_bits)
            nxt_st.rx_timeout = 1'b1;

        // leave one slot for a character already on the wire
        nxt_st.rts_n = cfg.flow_en && (rxf_level >= UST_RTS_OFF_LEVEL);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
            st_ff.txd <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign txd = st_ff.txd;
    assign sck = st_ff.sck;
    assign drv_en = st_ff.drv_en;
    assign rts_n = st_ff.rts_n;

    always_comb
    begin
        flags.parity_err = st_ff.parity_err;
        flags.overrun_err = st_ff.overrun_err;
        flags.frame_err = st_ff.frame_err;
        flags.break_det = st_ff.break_det;
        flags.rx_timeout = st_ff.rx_timeout;
        flags.tx_busy = (st_ff.tx_st != TX_IDLE);
        flags.rx_busy = (st_ff.rx_st != RX_IDLE);
        flags.tx_level = txf_level;
        flags.rx_level = rxf_level;
        irq.line_status = st_ff.parity_err || st_ff.overrun_err || st_ff.frame_err
            || st_ff.break_det;
        irq.tx_empty = (txf_level == '0);
        irq.rx_thresh = (cfg.rx_thresh != '0) && (rxf_level >= cfg.rx_thresh);
        irq.rx_timeout = st_ff.rx_timeout;
    end

    assign tx_dma_req = cfg.dma_en && txf_in_ready;
    assign rx_dma_req = cfg.dma_en && rx_valid;
endmodule

// ===== ust_core_sva.sv
// port-level assertion checker for the serial transceiver
`timescale 1ns/1ns
module ust_core_sva
    import ust_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire ust_cfg_t cfg,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire ust_flags_t flags,
    input wire ust_irq_t irq,
    input wire logic tx_dma_req,
    input wire logic rx_dma_req,
    input wire logic txd,
    input wire logic sck,
    input wire logic rts_n,
    input wire logic drv_en
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ****************************************
    // queue, interrupt and line relations
    // ****************************************
    property p_full; flags.tx_level == 4'h8 |-> !tx_ready; endproperty
    a_full: assert property (p_full) else $error("tx queue full yet ready");
    property p_empty; irq.tx_empty == (flags.tx_level == 4'h0); endproperty
    a_empty: assert property (p_empty) else $error("tx empty irq wrong");
    property p_thr; irq.rx_thresh == (cfg.rx_thresh != 4'h0 && flags.rx_level >= cfg.rx_thresh);
    endproperty
    a_thr: assert property (p_thr) else $error("rx threshold irq wrong");
    property p_line; irq.line_status == (flags.parity_err | flags.overrun_err
        | flags.frame_err | flags.break_det); endproperty
    a_line: assert property (p_line) else $error("line status irq wrong");
    property p_dma; tx_dma_req == (cfg.dma_en && tx_ready) && rx_dma_req == (cfg.dma_en && rx_valid);
    endproperty
    a_dma: assert property (p_dma) else $error("transfer request wrong");
    property p_rts; (cfg.flow_en && flags.rx_level >= 4'h7) [*2] |-> rts_n; endproperty
    a_rts: assert property (p_rts) else $error("ready-to-send kept low near full");
    property p_drv; $rose(drv_en) |-> !txd && flags.tx_busy; endproperty
    a_drv: assert property (p_drv) else $error("driver enable not at start bit");
    property p_rs; !cfg.rs485_en [*2] |-> !drv_en; endproperty
    a_rs: assert property (p_rs) else $error("driver enable outside line mode");
    property p_sck; !cfg.sync_mode [*2] |-> !sck; endproperty
    a_sck: assert property (p_sck) else $error("bit clock in async mode");
    property p_idle; !flags.tx_busy [*2] |-> txd != cfg.irda_en; endproperty
    a_idle: assert property (p_idle) else $error("idle line level wrong");
endmodule

// ===== ust_core_tb_top.sv
// self-checking testbench of the serial transceiver
`timescale 1ns/1ns
module ust_core_tb_top
    import ust_pkg::*;
;
    logic core_clk, rst, flags_clr, tx_valid, rx_ready, cts_n, tx_ready, rx_valid;
    logic tx_dma_req, rx_dma_req, txd, rxd, sck, rts_n, drv_en;
    logic [8:0] tx_data;
    logic [8:0] rx_data;
    ust_cfg_t cfg;
    ust_flags_t flags;
    ust_irq_t irq;
    int error_cnt;
    int checks;
    ust_core dut (.core_clk(core_clk), .rst(rst), .cfg(cfg), .flags_clr(flags_clr),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .flags(flags), .irq(irq), .tx_dma_req(tx_dma_req),
        .rx_dma_req(rx_dma_req), .txd(txd), .rxd(rxd), .sck(sck), .rts_n(rts_n), .cts_n(cts_n),
        .drv_en(drv_en));
    ust_remote #(.BIT(16)) rem (.core_clk(core_clk), .txd(txd), .rxd(rxd));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [10:0] frame(input logic [8:0] d, input int n, input logic msb,
        input logic pe, input logic po);
        logic [10:0] f;
        logic p;
        f = '1;
        p = po;
        for (int i = 0; i < n; i++)
        begin
            f[i] = msb ? d[n - 1 - i] : d[i];
            p ^= f[i];
        end
        if (pe)
            f[n] = p;
        return f;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [8:0] d);
        tx_valid <= 1'b1;
        tx_data <= d;
        @(posedge core_clk);
        tx_valid <= 1'b0;
    endtask
    task automatic pop();
        rx_ready <= 1'b1;
        flags_clr <= 1'b1;
        @(posedge core_clk);
        rx_ready <= 1'b0;
        flags_clr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_tx();
        logic [10:0] got;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge core_clk);
            cfg.wlen <= ust_wlen_t'(i);
            cfg.msb_first <= (i == 0);
            cfg.parity_en <= (i != 2);
            cfg.parity_odd <= (i == 0);
            cfg.two_stop <= (i != 1);
            cfg.rs485_en <= 1'b1;
            push(9'h1A5 ^ 9'(i));
            rem.get(got, (i == 2) ? 11 : 10);
            check(got, frame(9'h1A5 ^ 9'(i), 7 + i, i == 0, i != 2, i == 0));
            check(drv_en, 1'b1);
            repeat (16) @(posedge core_clk);
            check(drv_en, 1'b0);
        end
    endtask
    task automatic t_rx();
        logic [10:0] f;
        cfg.wlen <= UST_WL_8;
        cfg.msb_first <= 1'b0;
        cfg.parity_odd <= 1'b0;
        cfg.parity_en <= 1'b1;
        cfg.two_stop <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 3; i++)
        begin
            f = frame(9'h0C3 + 9'(i), 8, 1'b0, 1'b1, 1'b0);
            if (i == 1)
                f[8] = ~f[8];
            if (i == 2)
                f[9] = 1'b0;
            rem.send(f, 10);
            check({rx_valid, rx_data}, {1'b1, 9'h0C3 + 9'(i)});
            check({flags.parity_err, flags.frame_err}, {i == 1, i == 2});
            pop();
        end
    endtask
    task automatic t_ovr();
        cfg.flow_en <= 1'b1;
        cfg.rx_thresh <= 4'h4;
        cfg.timeout_bits <= 8'h04;
        for (int k = 0; k < 9; k++)
            rem.send(frame(9'(k), 8, 1'b0, 1'b1, 1'b0), 10);
        // five idle bit periods with a full queue: the timeout must be up by now
        repeat (64) @(posedge core_clk);
        check({flags.rx_level, flags.overrun_err, rts_n, rx_data}, {4'h8, 2'b11, 9'h000});
        check({flags.rx_timeout, irq.rx_timeout, irq.rx_thresh, irq.line_status}, 4'hF);
        repeat (8) pop();
        // ready-to-send is registered, so it follows the level one edge later
        @(posedge core_clk);
        check({flags.rx_level, rx_valid, rts_n}, 6'h00);
    endtask
    task automatic t_cts();
        logic [10:0] got;
        cfg.dma_en <= 1'b1;
        cts_n <= 1'b1;
        push(9'h05A);
        repeat (64) @(posedge core_clk);
        check({txd, flags.tx_level}, 5'h11);
        cts_n <= 1'b0;
        fork
            rem.send(frame(9'h033, 8, 1'b0, 1'b1, 1'b0), 10);
            rem.get(got, 10);
        join
        check(got, frame(9'h05A, 8, 1'b0, 1'b1, 1'b0));
        check({rx_valid, rx_data}, {1'b1, 9'h033});
        pop();
    endtask
    task automatic t_sync();
        logic [10:0] got;
        int n;
        n = 0;
        cfg.sync_mode <= 1'b1;
        cfg.baud_div <= 16'h0001;
        push(9'h0F0);
        fork
            rem.get(got, 10);
            repeat (200) @(posedge core_clk) n += int'(sck);
        join
        check(got, frame(9'h0F0, 8, 1'b0, 1'b1, 1'b0));
        check(16'(n), 16'h0040);
        cfg.wlen <= UST_WL_7;
        cfg.parity_en <= 1'b0;
        // twelve low bit periods against a nine-bit frame
        rem.send(11'h000, 11);
        check({flags.break_det, irq.line_status}, 2'b11);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // the scenarios need about 3700 cycles; over five times that means a hang
    initial
    begin
        #160000;
        error_cnt++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        flags_clr = 1'b0;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        cts_n = 1'b0;
        tx_data = 9'h000;
        cfg = '0;
        cfg.wlen = UST_WL_8;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check({tx_ready, rx_valid, irq.tx_empty, txd, rts_n, drv_en}, 6'h2C);
        t_tx();
        t_rx();
        t_ovr();
        t_cts();
        t_sync();
        results();
    end
endmodule
bind ust_core ust_core_sva chk (.core_clk(core_clk), .rst(rst), .cfg(cfg), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .flags(flags), .irq(irq), .tx_dma_req(tx_dma_req),
    .rx_dma_req(rx_dma_req), .txd(txd), .sck(sck), .rts_n(rts_n), .drv_en(drv_en));

// ===== ust_fifo.sv
// first-in first-out queue with valid/ready on both sides
`timescale 1ns/1ns
module ust_fifo
    import ust_pkg::*;
#(
    parameter int W = UST_DATA_W,
    parameter int D = UST_FIFO_DEPTH
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ust_fifo_st_t;

    ust_fifo_st_t st_ff;
    ust_fifo_st_t nxt_st;
    logic push;
    logic pop;

    assign in_ready = (st_ff.cnt != D[AW:0]);
    assign out_valid = (st_ff.cnt != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == AW'(D - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop)
            nxt_st.rd = (st_ff.rd == AW'(D - 1)) ? '0 : st_ff.rd + 1'b1;
        if (push && !pop)
            nxt_st.cnt = st_ff.cnt + 1'b1;
        else if (pop && !push)
            nxt_st.cnt = st_ff.cnt - 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign out_data = st_ff.mem[st_ff.rd];
    assign level = st_ff.cnt;
endmodule

// ===== ust_pkg.sv
// shared constants, enums and carrier structs of the serial transceiver
package ust_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int UST_DATA_W = 9;
    localparam int UST_FIFO_DEPTH = 8;
    localparam int UST_LVL_W = 4;
    localparam int UST_DIV_W = 16;

    // ****************************************
    // timing in sample ticks, and the ready-to-send queue level
    // ****************************************
    localparam logic [4:0] UST_TICKS_ASYNC = 5'h10;
    localparam logic [4:0] UST_TICKS_SYNC = 5'h08;
    localparam logic [4:0] UST_IR_PULSE_TICKS = 5'h03;
    localparam logic [3:0] UST_RTS_OFF_LEVEL = 4'h7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [8:0] UST_RST_SHIFT = 9'h000;
    localparam logic [4:0] UST_RST_TICK = 5'h00;
    localparam logic [7:0] UST_RST_CNT = 8'h00;

    typedef enum logic [1:0] {UST_WL_7, UST_WL_8, UST_WL_9} ust_wlen_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ust_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ust_rx_st_t;

    typedef struct packed {
        logic sync_mode;
        ust_wlen_t wlen;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic msb_first;
        logic flow_en;
        logic irda_en;
        logic rs485_en;
        logic dma_en;
        logic [UST_DIV_W-1:0] baud_div;
        logic [UST_LVL_W-1:0] rx_thresh;
        logic [7:0] timeout_bits;
    } ust_cfg_t;

    typedef struct packed {
        logic parity_err;
        logic overrun_err;
        logic frame_err;
        logic break_det;
        logic rx_timeout;
        logic tx_busy;
        logic rx_busy;
        logic [UST_LVL_W-1:0] tx_level;
        logic [UST_LVL_W-1:0] rx_level;
    } ust_flags_t;

    typedef struct packed {
        logic line_status;
        logic tx_empty;
        logic rx_thresh;
        logic rx_timeout;
    } ust_irq_t;

endpackage

// ===== ust_remote.sv
// remote serial device: drives the receive line and samples the transmit line
`timescale 1ns/1ns
module ust_remote
#(
    parameter int BIT = 16
)
(
    input wire logic core_clk,
    input wire logic txd,
    output logic rxd
);
    initial
    begin
        rxd = 1'b1;
    end
    // start bit, then n bits in wire order, then an idle bit as gap
    task automatic send(input logic [10:0] bits, input int n);
        rxd <= 1'b0;
        repeat (BIT) @(posedge core_clk);
        for (int i = 0; i < n; i++)
        begin
            rxd <= bits[i];
            repeat (BIT) @(posedge core_clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge core_clk);
    endtask
    // unsampled positions stay high so they match the stop level
    task automatic get(output logic [10:0] bits, input int n);
        bits = '1;
        while (txd !== 1'b0) @(posedge core_clk);
        repeat (BIT / 2) @(posedge core_clk);
        for (int i = 0; i < n; i++)
        begin
            repeat (BIT) @(posedge core_clk);
            bits[i] = txd;
        end
    endtask
endmodule

// ===== ust_tick_div.sv
// divider making the sample-tick enable from the bus clock
`timescale 1ns/1ns
module ust_tick_div
    import ust_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [UST_DIV_W-1:0] div,
    output logic tick
);
    typedef struct packed {
        logic [UST_DIV_W-1:0] cnt;
        logic tick;
    } ust_div_st_t;

    ust_div_st_t st_ff;
    ust_div_st_t nxt_st;

    // a divisor of zero gives one tick per clock, the fastest bit rate
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= div)
        begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;
endmodule
